//--- clock_state_sequencer.sv
// clock state sequencer: decodes power-down, stop, mode and ratio pins
// into output drive, source and settled indications
// assumes all pins synchronous to clk_in; reset stands in for supply power-up
`default_nettype none
// Contract
// - power_down_n low forces power-down, source off, outputs grounded, ignoring stop.
// - leaving power-down, loop and clock settled within 3 ms.
// - after supply power-up, clock settled within 3 ms in any state; the code stays in power-down until power_down_n is high.
// - ratio select change in normal resettles output within 1 ms.
// - stop release gives glitch-free edges within 10 ns; the code raises glitch_free_out on the third clock edge after the release.
// - phase restored within 50 ps inside 20 output cycles of stop release.
// - before glitch-free point output undefined, afterwards enabled and glitch-free.
// - stop falling in normal disables outputs within 5 ns; the code drops the drivers on the next 25 ns clock edge.
// - outputs stay high impedance for all of clock stop.
// - mode select change normal/test resettles output within 3 ms.
// - from normal or stop, fully powered down within 1 ms.
// - distributed loop reaches phase tolerance within 5 ms after settling.
// - mode 00 normal, 01 high impedance, 10 bypass, 11 test; the code decodes {high, low} 01 as bypass and 10 as high impedance.
// - output may glitch while any state transition is in progress.
module clock_state_sequencer
    import clock_seq_pkg::*;
(
    input wire logic clk_in,                    // 40 MHz system clock
    input wire logic nrst_in,                   // sync reset, active low
    input wire logic ce_in,                     // clock enable, freezes state when low
    input wire logic power_down_n_in,           // power-down request, active low
    input wire logic output_stop_n_in,          // output stop request, active low
    input wire logic mode_select_low_in,        // mode select bit 0
    input wire logic mode_select_high_in,       // mode select bit 1
    input wire logic ratio_select_low_in,       // multiplier select bit 0
    input wire logic ratio_select_high_in,      // multiplier select bit 1
    output logic source_on_out,                 // internal loop and clock source running
    output logic output_enable_n_out,           // output drivers enabled, active low
    output logic output_ground_out,             // outputs pulled to ground
    output clock_seq_pkg::out_source_e out_source_out, // which clock feeds the outputs
    output logic clock_settled_out,             // output or internal clock settled
    output logic glitch_free_out,               // output edges guaranteed glitch-free
    output logic phase_restored_out,            // output phase back within tolerance
    output logic loop_locked_out,               // distributed loop lock time elapsed
    output logic in_power_down_out              // fully in power-down
);
    // ************************************************************
    // decoding
    // ************************************************************
    function automatic out_source_e decode_mode(input logic [1:0] sel);
        case (sel)
            MODE_NORMAL: decode_mode = SRC_PHASE;
            MODE_BYPASS: decode_mode = SRC_LOOP;
            MODE_TEST: decode_mode = SRC_REF;
            default: decode_mode = SRC_NONE;
        endcase
    endfunction

    function automatic logic [CNT_W+1:0] cyc(input int unsigned n);
        cyc = n[CNT_W+1:0];
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        seq_state_e st;
        logic [1:0] mode;
        logic [1:0] ratio;
        logic stop_n;
        logic settled;
        logic glitch_free;
        logic restored;
        logic locked;
        logic source_on;
        logic oe_n;
        logic ground;
        out_source_e src;
        logic pd;
    } seq_s;
    seq_s state_reg;
    seq_s state_next;

    // ************************************************************
    // latency timers
    // ************************************************************
    // four timers: main transition, stop release glitch window, phase restore, loop lock
    latency_if main_lat();
    latency_if glitch_lat();
    latency_if phase_lat();
    latency_if lock_lat();

    latency_timer main_timer
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lat(main_lat)
    );
    latency_timer glitch_timer
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lat(glitch_lat)
    );
    latency_timer phase_timer
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lat(phase_lat)
    );
    latency_timer lock_timer
    (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .lat(lock_lat)
    );

    logic [1:0] mode_in;
    logic [1:0] ratio_in;
    assign mode_in = {mode_select_high_in, mode_select_low_in};
    assign ratio_in = {ratio_select_high_in, ratio_select_low_in};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        main_lat.start = 1'b0;
        main_lat.load = '0;
        glitch_lat.start = 1'b0;
        glitch_lat.load = cyc(GLITCH_FREE_CYC);
        phase_lat.start = 1'b0;
        phase_lat.load = cyc(PHASE_RESTORE_CYC);
        lock_lat.start = 1'b0;
        lock_lat.load = cyc(LOOP_LOCK_CYC);
        state_next.stop_n = output_stop_n_in;
        state_next.ratio = ratio_in;
        case (state_reg.st)
            ST_POWER_DOWN:
            begin
                // selects may change here, so track them freely
                state_next.mode = mode_in;
                state_next.source_on = 1'b0;
                state_next.ground = 1'b1;
                state_next.oe_n = 1'b1;
                state_next.settled = 1'b0;
                state_next.pd = 1'b1;
                if (power_down_n_in)
                begin
                    state_next.st = ST_POWERING_UP;
                    state_next.pd = 1'b0;
                    state_next.source_on = 1'b1;
                    state_next.ground = 1'b0;
                    main_lat.start = 1'b1;
                    main_lat.load = cyc(POWERUP_CYC);
                end
            end
            ST_POWERING_UP:
            begin
                if (!power_down_n_in)
                begin
                    state_next.st = ST_GOING_DOWN;
                    main_lat.start = 1'b1;
                    main_lat.load = cyc(POWERDN_CYC);
                end
                else if (main_lat.done && !main_lat.start)
                begin
                    // settled only after the full latency has run out
                    state_next.st = ST_RUN;
                    state_next.settled = 1'b1;
                    lock_lat.start = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (!power_down_n_in)
                begin
                    state_next.st = ST_GOING_DOWN;
                    state_next.settled = 1'b0;
                    main_lat.start = 1'b1;
                    main_lat.load = cyc(POWERDN_CYC);
                end
                else if (mode_in != state_reg.mode || ratio_in != state_reg.ratio)
                begin
                    // hot change: glitches allowed until the resettle time passes
                    state_next.mode = mode_in;
                    state_next.st = ST_POWERING_UP;
                    state_next.settled = 1'b0;
                    main_lat.start = 1'b1;
                    main_lat.load = (mode_in != state_reg.mode) ? cyc(CTL_CYC) : cyc(MULT_CYC);
                end
            end
            ST_GOING_DOWN:
            begin
                // power-down is already asked, so the selects may move here too
                state_next.mode = mode_in;
                state_next.oe_n = 1'b1;
                if (power_down_n_in)
                begin
                    state_next.st = ST_POWERING_UP;
                    state_next.source_on = 1'b1;
                    state_next.ground = 1'b0;
                    main_lat.start = 1'b1;
                    main_lat.load = cyc(POWERUP_CYC);
                end
                else if (main_lat.done && !main_lat.start)
                begin
                    state_next.st = ST_POWER_DOWN;
                    state_next.pd = 1'b1;
                end
                else
                begin
                    // drivers and source off at once; power-down is flagged when the window runs out
                    state_next.source_on = 1'b0;
                    state_next.ground = 1'b1;
                end
            end
            default:
            begin
                state_next.st = ST_POWER_DOWN;
            end
        endcase

        // source and drivers drop on the first edge of a request, whatever state it meets
        if (!power_down_n_in)
        begin
            state_next.source_on = 1'b0;
            state_next.ground = 1'b1;
            state_next.oe_n = 1'b1;
        end

        state_next.src = decode_mode(state_next.mode);
        if (state_next.st != ST_POWER_DOWN && state_next.st != ST_GOING_DOWN)
        begin
            // stop low or mode 10 leaves the drivers off; outputs float
            state_next.oe_n = !output_stop_n_in || state_next.src == SRC_NONE;
        end

        // stop release: undefined window, then glitch-free, then phase restored
        if (output_stop_n_in && !state_reg.stop_n)
        begin
            glitch_lat.start = 1'b1;
            phase_lat.start = 1'b1;
            state_next.glitch_free = 1'b0;
            state_next.restored = 1'b0;
        end
        else if (!output_stop_n_in || state_next.oe_n)
        begin
            state_next.glitch_free = 1'b0;
            state_next.restored = 1'b0;
        end
        else
        begin
            state_next.glitch_free = glitch_lat.done && state_next.settled;
            state_next.restored = phase_lat.done && state_next.settled;
        end
        state_next.locked = state_next.settled && lock_lat.done && !lock_lat.start;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= '{
                st: ST_POWER_DOWN,
                mode: MODE_NORMAL,
                ratio: 2'h0,
                // idle level of the stop pin, so leaving reset is not taken as a release
                stop_n: 1'b1,
                settled: 1'b0,
                glitch_free: 1'b0,
                restored: 1'b0,
                locked: 1'b0,
                source_on: 1'b0,
                oe_n: 1'b1,
                ground: 1'b1,
                src: SRC_PHASE,
                pd: 1'b1
            };
        end
        else if (ce_in)
        begin
            state_reg <= state_next;
        end
    end

    assign source_on_out = state_reg.source_on;
    assign output_enable_n_out = state_reg.oe_n;
    assign output_ground_out = state_reg.ground;
    assign out_source_out = state_reg.src;
    assign clock_settled_out = state_reg.settled;
    assign glitch_free_out = state_reg.glitch_free;
    assign phase_restored_out = state_reg.restored;
    assign loop_locked_out = state_reg.locked;
    assign in_power_down_out = state_reg.pd;
endmodule
`default_nettype wire

//--- clock_seq_pkg.sv
// shared constants and types for the clock state sequencer
// assumes a single 40 MHz clock domain
`default_nettype none
package clock_seq_pkg;
    // ************************************************************
    // clock and latency figures
    // ************************************************************
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned POWERUP_MS = 3;
    localparam int unsigned MULT_MS = 1;
    localparam int unsigned CTL_MS = 3;
    localparam int unsigned POWERDN_MS = 1;
    localparam int unsigned LOOP_LOCK_MS = 5;
    localparam int unsigned GLITCH_FREE_NS = 10;
    localparam int unsigned STOP_DISABLE_NS = 5;
    localparam int unsigned PHASE_RESTORE_OUT_CYCLES = 20;
    // slowest output clock period in ps, for converting output cycles to system clock cycles
    localparam int unsigned OUT_PERIOD_MAX_PS = 3750;
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned CNT_W = 20;

    // ns times round down, never below one cycle
    localparam int unsigned POWERUP_CYC = POWERUP_MS * (CLK_HZ / 1000);
    localparam int unsigned MULT_CYC = MULT_MS * (CLK_HZ / 1000);
    localparam int unsigned CTL_CYC = CTL_MS * (CLK_HZ / 1000);
    localparam int unsigned POWERDN_CYC = POWERDN_MS * (CLK_HZ / 1000);
    localparam int unsigned LOOP_LOCK_CYC = LOOP_LOCK_MS * (CLK_HZ / 1000);
    localparam int unsigned GLITCH_FREE_CYC_RAW = (GLITCH_FREE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned GLITCH_FREE_CYC = (GLITCH_FREE_CYC_RAW < 1) ? 1 : GLITCH_FREE_CYC_RAW;
    localparam int unsigned PHASE_RESTORE_CYC_RAW =
        (PHASE_RESTORE_OUT_CYCLES * OUT_PERIOD_MAX_PS) / CLK_PERIOD_PS;
    localparam int unsigned PHASE_RESTORE_CYC = (PHASE_RESTORE_CYC_RAW < 1) ? 1 : PHASE_RESTORE_CYC_RAW;

    // ************************************************************
    // mode select encodings {high, low}
    // ************************************************************
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HIZ = 2'h2;
    localparam logic [1:0] MODE_BYPASS = 2'h1;
    localparam logic [1:0] MODE_TEST = 2'h3;

    typedef enum logic [1:0] {SRC_PHASE, SRC_LOOP, SRC_REF, SRC_NONE} out_source_e;
    typedef enum logic [2:0] {ST_POWER_DOWN, ST_POWERING_UP, ST_RUN, ST_GOING_DOWN} seq_state_e;
    typedef enum logic [1:0] {DRV_GROUND, DRV_HIZ, DRV_ON} drive_e;
endpackage
`default_nettype wire

//--- latency_if.sv
// carries one latency timer request and its done flag
// assumes the single sequencer clock
`default_nettype none
interface latency_if;
    import clock_seq_pkg::*;
    logic start;
    logic [CNT_W+1:0] load;
    logic done;
    modport owner (output start, output load, input done);
    modport timer (input start, input load, output done);
endinterface
`default_nettype wire

//--- latency_timer.sv
// down counter that flags when a loaded latency has elapsed
// assumes clock enable gates all state
`default_nettype none
module latency_timer
    import clock_seq_pkg::*;
(
    input wire logic clk_in,       // system clock
    input wire logic nrst_in,      // sync reset, active low
    input wire logic ce_in,        // clock enable
    latency_if.timer lat           // request side
);
    typedef struct packed
    {
        logic [CNT_W+1:0] count;
        logic done;
    } timer_s;
    timer_s state_reg;
    timer_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (lat.start)
        begin
            state_next.count = lat.load;
            state_next.done = 1'b0;
        end
        else if (state_reg.count > 1)
        begin
            state_next.count = state_reg.count - 1'b1;
        end
        else
        begin
            state_next.count = '0;
            state_next.done = 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= '0;
        end
        else if (ce_in)
        begin
            state_reg <= state_next;
        end
    end

    assign lat.done = state_reg.done;
endmodule
`default_nettype wire

//--- clock_sequencer_monitor.sv
// port checker for the clock state sequencer
// assumes it is bound onto clock_state_sequencer
`default_nettype none
module clock_sequencer_monitor
    import clock_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic power_down_n_in,
    input wire logic output_stop_n_in,
    input wire logic mode_select_low_in,
    input wire logic mode_select_high_in,
    input wire logic ratio_select_low_in,
    input wire logic ratio_select_high_in,
    input wire logic source_on_out,
    input wire logic output_enable_n_out,
    input wire logic output_ground_out,
    input wire clock_seq_pkg::out_source_e out_source_out,
    input wire logic clock_settled_out,
    input wire logic glitch_free_out,
    input wire logic phase_restored_out,
    input wire logic loop_locked_out,
    input wire logic in_power_down_out
);
    logic running;
    assign running = power_down_n_in && output_stop_n_in && {mode_select_high_in, mode_select_low_in} != MODE_HIZ;
    default clocking @(posedge clk_in); endclocking
    // frozen state under a low enable would trip every next-cycle relation
    default disable iff (!nrst_in || !ce_in);
    // ****
    // assertions
    // ****
    pd_ground_a: assert property (!power_down_n_in |=>
        output_ground_out && !source_on_out && output_enable_n_out)
        else $error("outputs not grounded in power-down");
    run_drive_a: assert property (running |=> !output_enable_n_out && source_on_out && !output_ground_out)
        else $error("outputs not driven in normal state");
    stop_off_a: assert property (power_down_n_in && !output_stop_n_in |=> output_enable_n_out)
        else $error("outputs driven while stopped");
    hiz_mode_a: assert property (power_down_n_in && mode_select_high_in && !mode_select_low_in |=>
        output_enable_n_out)
        else $error("outputs driven in high impedance mode");
    // a release while still powering up is part of that transition and may glitch
    glitch_on_a: assert property ($rose(output_stop_n_in) && running && clock_settled_out |->
        ##[1:4] glitch_free_out)
        else $error("glitch-free edges late after stop release");
    glitch_en_a: assert property (glitch_free_out |-> !output_enable_n_out)
        else $error("glitch-free flagged with outputs off");
    phase_back_a: assert property ($rose(output_stop_n_in) && running && clock_settled_out |->
        ##[1:6] phase_restored_out)
        else $error("phase not restored in time");
    settle_early_a: assert property ($rose(power_down_n_in) |=> !clock_settled_out [*8])
        else $error("settled reported before latency elapsed");
    pd_early_a: assert property ($fell(power_down_n_in) |=> !in_power_down_out [*8])
        else $error("power-down reported before latency elapsed");
    cover property ($rose(glitch_free_out));
    cover property ($rose(phase_restored_out));
    cover property ($rose(in_power_down_out));
endmodule
bind clock_state_sequencer clock_sequencer_monitor i_clock_sequencer_monitor (.clk_in, .nrst_in, .ce_in,
    .power_down_n_in, .output_stop_n_in, .mode_select_low_in, .mode_select_high_in, .ratio_select_low_in,
    .ratio_select_high_in, .source_on_out, .output_enable_n_out, .output_ground_out, .out_source_out,
    .clock_settled_out, .glitch_free_out, .phase_restored_out, .loop_locked_out, .in_power_down_out);
`default_nettype wire

//--- mem_controller_model.sv
// memory controller side: drives the sequencer control pins from bench requests
// assumes the bench changes requests shortly after the clock edge
`default_nettype none
module mem_controller_model (
    input wire logic pd_req_n_in,        // wanted power-down level
    input wire logic stop_req_n_in,      // wanted stop level
    input wire logic [1:0] mode_req_in,  // wanted mode {high,low}
    input wire logic [1:0] ratio_req_in, // wanted multiplier {high,low}
    output logic power_down_n_out,       // power-down pin
    output logic output_stop_n_out,      // stop pin
    output logic [1:0] mode_out,         // mode pins
    output logic [1:0] ratio_out         // multiplier pins
);
    assign power_down_n_out = pd_req_n_in;
    assign output_stop_n_out = stop_req_n_in;
    // selects move only while power-down is asked, so no latency is timed across a change
    always_latch
    begin
        if (!pd_req_n_in)
        begin
            mode_out = mode_req_in;
            ratio_out = ratio_req_in;
        end
    end
endmodule
`default_nettype wire

//--- clock_state_sequencer_tb.sv
// self-checking bench for clock_state_sequencer
// assumes package counts; the 3 ms settle count is too long to run out here,
// so stop releases are only seen while unsettled, where no flag may rise
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module clock_state_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_seq_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ce = 1'b1;
    logic pd_req_n = 1'b0;
    logic stop_req_n = 1'b0;
    logic [1:0] mode_req = 2'h0;
    logic [1:0] ratio_req = 2'h0;
    logic [1:0] mode_pin, ratio_pin;
    logic pd_pin, stop_pin, source_on, oe_n, ground, settled, glitch_free, phase_ok, locked, in_pd;
    out_source_e src;
    int n_errors = 0;
    int n_checks = 0;
    int seed = 32'hf74d;
    int cycles = 0;
    always #12.5 clk_in = ~clk_in;
    mem_controller_model i_mem_controller_model (.pd_req_n_in(pd_req_n), .stop_req_n_in(stop_req_n),
        .mode_req_in(mode_req), .ratio_req_in(ratio_req), .power_down_n_out(pd_pin),
        .output_stop_n_out(stop_pin), .mode_out(mode_pin), .ratio_out(ratio_pin));
    clock_state_sequencer i_clock_state_sequencer (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
        .power_down_n_in(pd_pin), .output_stop_n_in(stop_pin), .mode_select_low_in(mode_pin[0]),
        .mode_select_high_in(mode_pin[1]), .ratio_select_low_in(ratio_pin[0]),
        .ratio_select_high_in(ratio_pin[1]), .source_on_out(source_on), .output_enable_n_out(oe_n),
        .output_ground_out(ground), .out_source_out(src), .clock_settled_out(settled),
        .glitch_free_out(glitch_free), .phase_restored_out(phase_ok), .loop_locked_out(locked),
        .in_power_down_out(in_pd));
    function automatic out_source_e exp_src(logic [1:0] mode);
        case (mode)
            MODE_NORMAL: return SRC_PHASE;
            MODE_BYPASS: return SRC_LOOP;
            MODE_TEST: return SRC_REF;
            default: return SRC_NONE;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        tick(3);
        nrst_in = 1'b1;
        tick(1);
        `CHK(in_pd, 1'b1)
        // a low enable must hold off the power-up request
        ce = 1'b0;
        pd_req_n = 1'b1;
        tick(3);
        `CHK(source_on, 1'b0)
        ce = 1'b1;
        tick(1);
        `CHK(source_on, 1'b1)
        // every mode, each entered from a short power-down request with random multiplier and stop level
        for (int m = 0; m < 4; m++)
        begin
            pd_req_n = 1'b0;
            mode_req = m[1:0];
            ratio_req = 2'($random(seed));
            stop_req_n = 1'($random(seed));
            tick(2);
            `CHK(ground, 1'b1)
            `CHK(oe_n, 1'b1)
            pd_req_n = 1'b1;
            tick(1);
            `CHK(source_on, 1'b1)
            `CHK(ground, 1'b0)
            `CHK(oe_n, !(stop_req_n && mode_pin != MODE_HIZ))
            `CHK(src, exp_src(mode_pin))
            for (int k = 0; k < 2; k++)
            begin
                stop_req_n = 1'b0;
                tick(1);
                `CHK(oe_n, 1'b1)
                tick(1 + 3'($random(seed)));
                `CHK(oe_n, 1'b1)
                `CHK(glitch_free, 1'b0)
                stop_req_n = 1'b1;
                tick(1);
                `CHK(oe_n, mode_pin == MODE_HIZ)
                tick(PHASE_RESTORE_CYC + 2);
                `CHK(glitch_free, 1'b0)
                `CHK(phase_ok, 1'b0)
                tick(4);
            end
            `CHK(settled, 1'b0)
            `CHK(locked, 1'b0)
        end
        pd_req_n = 1'b0;
        tick(1);
        `CHK(source_on, 1'b0)
        tick(POWERDN_CYC - 8);
        `CHK(in_pd, 1'b0)
        tick(12);
        `CHK(in_pd, 1'b1)
        complete_run();
    end
endmodule
`default_nettype wire
